// file: rtl/ppd_charge_acc.sv
`timescale 1ns/1ns
`default_nettype none
module ppd_charge_acc
   import ppd_pkg::*;
#(
   parameter int WIDTH = PPD_CHG_WIDTH
) (
   input  wire logic             clock_in,
   input  wire logic             nrst_in,
   input  wire logic             accumulate_in,
   input  wire logic [7:0]       sample_in,
   input  wire logic             clear_in,
   input  wire logic [WIDTH-1:0] threshold_in,
   output logic      [WIDTH-1:0] total_out,
   output logic                  reached_out
);
   typedef struct packed {
      logic [WIDTH-1:0] total;
   } ppd_acc_st_t;

   ppd_acc_st_t st_reg;
   ppd_acc_st_t st_next;

   initial begin
      if (WIDTH < 9) $error("accumulator too narrow");
   end

   always_comb begin
      st_next = st_reg;
      if (clear_in) begin
         st_next.total = '0;
      end else if (accumulate_in && st_reg.total < threshold_in) begin
         st_next.total = st_reg.total + WIDTH'(sample_in);
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign total_out   = st_reg.total;
   assign reached_out = (threshold_in != '0) && (st_reg.total >= threshold_in);
endmodule
`default_nettype wire

// file: rtl/ppd_pkg.sv
package ppd_pkg;

   localparam int PPD_DISCH_TIME_US = 200;
   localparam int PPD_CLK_MHZ       = 250;
   localparam int PPD_DISCH_CYCLES  = PPD_DISCH_TIME_US * PPD_CLK_MHZ;
   localparam int PPD_CHG_WIDTH     = 24;

   localparam logic [1:0] PPD_BEH_REPORT     = 2'h0;
   localparam logic [1:0] PPD_BEH_REPORT_DISC = 2'h1;
   localparam logic [1:0] PPD_BEH_DISC_SLEEP = 2'h2;
   localparam logic [1:0] PPD_BEH_IGNORE     = 2'h3;
   localparam logic [1:0] PPD_BEH_RESET      = PPD_BEH_REPORT_DISC;

   typedef enum logic [3:0] {
      PPD_OFF    = 4'h1,
      PPD_ACTIVE = 4'h2,
      PPD_SLEEP  = 4'h4,
      PPD_ERROR  = 4'h8
   } ppd_pstate_t;

   // per-port pin and control inputs
   typedef struct packed {
      logic       enable;
      logic       manual_load;
      logic       disch_cmd;
      logic       sleep_cmd;
      logic       err_clear;
      logic       vbus_above_test;
      logic       charge_limit_reached_flag_rst;
      logic [1:0] action_sel;
   } ppd_port_in_t;

   // per-port outputs
   typedef struct packed {
      logic       switch_closed;
      logic       discharge_load;
      logic       fault_alert;
      logic       discharge_fault_flag;
      logic       charge_limit_reached_flag;
      logic       monitor_on;
      logic [3:0] power_state;
   } ppd_port_out_t;

endpackage

// file: rtl/ppd_port_ctrl.sv
// Functional notes
// - high die temperature opens both switches
// - high temperature errors both ports, asserts alerts
// - stay in error until below hysteresis
// - auto discharge only when enable bit set
// - five triggers start automatic discharge
// - vbus high after window sets fault, error
// - auto discharge off means no automatic action
// - manual load bit connects discharge resistor
// - rationing accumulates only while active
// - behaviour change leaves charge totals intact
// - change before threshold acts silently
// - change after threshold adopted immediately
// - action select encodes threshold behaviour
// - report-disconnect keeps switch open until reset
// - disconnect-sleep stops monitoring, ignores enables
// - rationing reset clears totals, flag, alert
`timescale 1ns/1ns
`default_nettype none
module ppd_port_ctrl
   import ppd_pkg::*;
#(
   parameter int NPORTS        = 2,
   parameter int DISCH_CYCLES  = PPD_DISCH_CYCLES,
   parameter int CHG_WIDTH     = PPD_CHG_WIDTH
) (
   input  wire logic                 clock_in,
   input  wire logic                 nrst_in,
   input  wire logic                 die_temp_high_in,
   input  wire logic                 die_temp_cool_in,
   input  wire logic                 supply_undervoltage_in,
   input  wire logic                 auto_discharge_enable_in,
   input  wire ppd_port_in_t [1:0]   port_in,
   input  wire logic [7:0]           charge_sample_in [2],
   input  wire logic [CHG_WIDTH-1:0] charge_threshold_in,
   output ppd_port_out_t [1:0]       port_out,
   output logic [CHG_WIDTH-1:0]      charge_total_out [2]
);
   localparam int TW = $clog2(DISCH_CYCLES + 1);

   typedef struct packed {
      logic [1:0]         en_prev;
      logic [1:0]         uv_prev;
      logic [1:0]         disch_active;
      logic [1:0][TW-1:0] disch_cnt;
      logic [1:0]         disch_fault;
      logic [1:0]         reached;
      logic [1:0]         alert;
      logic [1:0]         hold_open;
      logic [1:0]         frozen;
      logic               thermal_err;
      logic [1:0][3:0]    pstate;
      logic [1:0][1:0]    beh_prev;
   } ppd_st_t;

   ppd_st_t st_reg;
   ppd_st_t st_next;

   logic [6:0] pins_sync;
   logic [1:0] hot_s;
   logic       uv_s;
   logic [1:0] en_s;
   logic [1:0] vbus_hi_s;
   logic [1:0] acc_reached;
   logic [1:0] acc_clear;

   initial begin
      if (NPORTS != 2) $error("block serves exactly two ports");
      if (DISCH_CYCLES < 1) $error("discharge window too short");
   end

   ppd_sync2 #(.WIDTH(7)) u_sync (
      .clock_in (clock_in),
      .nrst_in  (nrst_in),
      .d_in     ({die_temp_high_in, die_temp_cool_in, supply_undervoltage_in,
                  port_in[1].enable, port_in[0].enable,
                  port_in[1].vbus_above_test, port_in[0].vbus_above_test}),
      .q_out    (pins_sync)
   );
   assign hot_s     = pins_sync[6:5];
   assign uv_s      = pins_sync[4];
   assign en_s      = pins_sync[3:2];
   assign vbus_hi_s = pins_sync[1:0];

   function automatic logic beh_alerts(input logic [1:0] beh);
      return (beh == PPD_BEH_REPORT) || (beh == PPD_BEH_REPORT_DISC);
   endfunction

   function automatic logic beh_opens(input logic [1:0] beh);
      return (beh == PPD_BEH_REPORT_DISC) || (beh == PPD_BEH_DISC_SLEEP);
   endfunction

   genvar g;
   for (g = 0; g < 2; g++) begin : g_acc
      ppd_charge_acc #(.WIDTH(CHG_WIDTH)) u_acc (
         .clock_in      (clock_in),
         .nrst_in       (nrst_in),
         .accumulate_in (st_reg.pstate[g] == PPD_ACTIVE),
         .sample_in     (charge_sample_in[g]),
         .clear_in      (acc_clear[g]),
         .threshold_in  (charge_threshold_in),
         .total_out     (charge_total_out[g]),
         .reached_out   (acc_reached[g])
      );
   end

   always_comb begin
      logic       trig;
      logic [1:0] beh;
      logic       want_on;
      st_next = st_reg;
      trig    = 1'b0;
      beh     = '0;
      want_on = 1'b0;
      for (int i = 0; i < 2; i++) begin
         acc_clear[i] = port_in[i].charge_limit_reached_flag_rst;
      end
      // thermal stage two with hysteresis
      if (hot_s[1]) begin
         st_next.thermal_err = 1'b1;
      end else if (hot_s[0]) begin
         st_next.thermal_err = 1'b0;
      end
      st_next.uv_prev = {uv_s, uv_s};
      for (int i = 0; i < 2; i++) begin
         beh     = port_in[i].action_sel;
         want_on = en_s[i];
         st_next.en_prev[i]  = en_s[i];
         st_next.beh_prev[i] = beh;
         // rationing threshold actions
         if (acc_reached[i] && !st_reg.reached[i] && !port_in[i].charge_limit_reached_flag_rst) begin
            st_next.reached[i] = 1'b1;
         end
         if (port_in[i].charge_limit_reached_flag_rst) begin
            st_next.reached[i] = 1'b0;
         end
         if (st_next.reached[i]) begin
            // behaviour change after threshold adopted at once
            st_next.alert[i]     = beh_alerts(beh);
            st_next.hold_open[i] = beh_opens(beh);
            st_next.frozen[i]    = (beh == PPD_BEH_DISC_SLEEP);
         end else begin
            // before threshold nothing is visible
            st_next.alert[i]     = 1'b0;
            st_next.hold_open[i] = 1'b0;
            st_next.frozen[i]    = 1'b0;
         end
         // automatic discharge triggers
         trig = (st_reg.en_prev[i] && !en_s[i] && !st_reg.frozen[i])
              || (uv_s && !st_reg.uv_prev[i] && st_reg.pstate[i] == PPD_ACTIVE)
              || (port_in[i].sleep_cmd && st_reg.pstate[i] != PPD_SLEEP)
              || (st_reg.pstate[i] == PPD_ERROR && st_next.pstate[i] != PPD_ERROR)
              || (port_in[i].disch_cmd && st_reg.pstate[i] == PPD_ACTIVE);
         if (auto_discharge_enable_in && trig && !st_reg.disch_active[i]) begin
            st_next.disch_active[i] = 1'b1;
            st_next.disch_cnt[i]    = TW'(DISCH_CYCLES);
         end else if (st_reg.disch_active[i]) begin
            if (st_reg.disch_cnt[i] == TW'(1)) begin
               st_next.disch_active[i] = 1'b0;
               st_next.disch_cnt[i]    = '0;
               if (vbus_hi_s[i]) begin
                  st_next.disch_fault[i] = 1'b1;
               end
            end else begin
               st_next.disch_cnt[i] = st_reg.disch_cnt[i] - TW'(1);
            end
         end
         if (port_in[i].err_clear && !(st_reg.disch_active[i] && st_reg.disch_cnt[i] == TW'(1))) begin
            st_next.disch_fault[i] = 1'b0;
         end
         // power state
         if (st_next.thermal_err || st_next.disch_fault[i]) begin
            st_next.pstate[i] = PPD_ERROR;
         end else if (st_next.frozen[i]) begin
            st_next.pstate[i] = PPD_SLEEP;
         end else if (port_in[i].sleep_cmd) begin
            st_next.pstate[i] = PPD_SLEEP;
         end else if (uv_s) begin
            st_next.pstate[i] = PPD_OFF;
         end else if (want_on) begin
            st_next.pstate[i] = PPD_ACTIVE;
         end else begin
            st_next.pstate[i] = PPD_OFF;
         end
      end
      // recovery from error discharge trigger evaluated on registered state against the final next power state
      for (int i = 0; i < 2; i++) begin
         if (auto_discharge_enable_in && st_reg.pstate[i] == PPD_ERROR
             && st_next.pstate[i] != PPD_ERROR && !st_reg.disch_active[i]) begin
            st_next.disch_active[i] = 1'b1;
            st_next.disch_cnt[i]    = TW'(DISCH_CYCLES);
         end
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg        <= '0;
         st_reg.pstate <= {PPD_OFF, PPD_OFF};
         st_reg.beh_prev <= {PPD_BEH_RESET, PPD_BEH_RESET};
      end else begin
         st_reg <= st_next;
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         port_out[i].switch_closed = (st_reg.pstate[i] == PPD_ACTIVE)
                                   && !st_reg.thermal_err && !st_reg.hold_open[i];
         port_out[i].discharge_load = st_reg.disch_active[i] || port_in[i].manual_load;
         port_out[i].fault_alert = st_reg.thermal_err || st_reg.disch_fault[i] || st_reg.alert[i];
         port_out[i].discharge_fault_flag = st_reg.disch_fault[i];
         port_out[i].charge_limit_reached_flag = st_reg.reached[i];
         port_out[i].monitor_on = !st_reg.frozen[i];
         port_out[i].power_state = st_reg.pstate[i];
      end
   end

   property p_thermal_opens;
      @(posedge clock_in) disable iff (!nrst_in)
      hot_s[1] |=> st_reg.thermal_err && !port_out[0].switch_closed && !port_out[1].switch_closed;
   endproperty
   a_thermal_opens: assert property (p_thermal_opens) else $error("switch closed when hot");

   property p_thermal_alert;
      @(posedge clock_in) disable iff (!nrst_in)
      $rose(st_reg.thermal_err) |-> port_out[0].fault_alert && port_out[1].fault_alert;
   endproperty
   a_thermal_alert: assert property (p_thermal_alert) else $error("alert missing when hot");

   property p_thermal_hold;
      @(posedge clock_in) disable iff (!nrst_in)
      st_reg.thermal_err && !hot_s[0] |=> st_reg.thermal_err;
   endproperty
   a_thermal_hold: assert property (p_thermal_hold) else $error("left error before cooling");

   property p_no_auto;
      @(posedge clock_in) disable iff (!nrst_in)
      !auto_discharge_enable_in && !st_reg.disch_active[0] |=> !st_reg.disch_active[0];
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("auto discharge while disabled");

   property p_manual_load;
      @(posedge clock_in) disable iff (!nrst_in)
      port_in[1].manual_load |-> port_out[1].discharge_load;
   endproperty
   a_manual_load: assert property (p_manual_load) else $error("manual load not applied");

   property p_charge_limit_reached_flag_reset;
      @(posedge clock_in) disable iff (!nrst_in)
      port_in[0].charge_limit_reached_flag_rst |=> !st_reg.reached[0] && !st_reg.alert[0];
   endproperty
   a_charge_limit_reached_flag_reset: assert property (p_charge_limit_reached_flag_reset) else $error("rationing reset ignored");

   property p_ignore_quiet;
      @(posedge clock_in) disable iff (!nrst_in)
      st_reg.reached[0] && port_in[0].action_sel == PPD_BEH_IGNORE && !port_in[0].charge_limit_reached_flag_rst
      |=> !st_reg.alert[0] && !st_reg.hold_open[0];
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignore behaviour acted");

   property p_sleep_frozen;
      @(posedge clock_in) disable iff (!nrst_in)
      st_reg.frozen[0] && !st_reg.thermal_err && !st_reg.disch_fault[0] |-> st_reg.pstate[0] == PPD_SLEEP;
   endproperty
   a_sleep_frozen: assert property (p_sleep_frozen) else $error("frozen port not asleep");

   // end of the discharge window with vbus still above the test level
   sequence s_window_end_high;
      st_reg.disch_active[0] && st_reg.disch_cnt[0] == TW'(1) && vbus_hi_s[0];
   endsequence

   sequence s_fault_entered;
      st_reg.disch_fault[0] && st_reg.pstate[0] == PPD_ERROR;
   endsequence

   property p_disch_fault;
      @(posedge clock_in) disable iff (!nrst_in)
      s_window_end_high |=> s_fault_entered;
   endproperty
   a_disch_fault: assert property (p_disch_fault) else $error("discharge fault not flagged");

   property p_auto_start;
      @(posedge clock_in) disable iff (!nrst_in)
      auto_discharge_enable_in && st_reg.en_prev[0] && !en_s[0] && !st_reg.frozen[0] && !st_reg.disch_active[0]
      |=> st_reg.disch_active[0];
   endproperty
   a_auto_start: assert property (p_auto_start) else $error("enable edge did not start discharge");

   property p_accum_active;
      @(posedge clock_in) disable iff (!nrst_in)
      st_reg.pstate[0] != PPD_ACTIVE && !port_in[0].charge_limit_reached_flag_rst
      |=> charge_total_out[0] == $past(charge_total_out[0]);
   endproperty
   a_accum_active: assert property (p_accum_active) else $error("charge grew outside active");

   property p_beh_keeps_total;
      @(posedge clock_in) disable iff (!nrst_in)
      port_in[0].action_sel != st_reg.beh_prev[0] && !port_in[0].charge_limit_reached_flag_rst
      |=> charge_total_out[0] >= $past(charge_total_out[0]);
   endproperty
   a_beh_keeps_total: assert property (p_beh_keeps_total) else $error("behaviour change lost charge");

   property p_report_disc_open;
      @(posedge clock_in) disable iff (!nrst_in)
      st_reg.reached[0] && port_in[0].action_sel == PPD_BEH_REPORT_DISC && !port_in[0].charge_limit_reached_flag_rst
      |=> !port_out[0].switch_closed && port_out[0].fault_alert;
   endproperty
   a_report_disc_open: assert property (p_report_disc_open) else $error("report disconnect not held");
endmodule
`default_nettype wire

// file: rtl/ppd_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module ppd_sync2
   import ppd_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } ppd_sync_st_t;

   ppd_sync_st_t st_reg;
   ppd_sync_st_t st_next;

   initial begin
      if (WIDTH < 1) $error("width must be positive");
   end

   always_comb begin
      st_next.s1 = d_in;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q_out = st_reg.s2;
endmodule
`default_nettype wire

// file: test/ppd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ppd_host_model #(
   parameter int HOLD = 12
) (
   input  wire logic       clock_in,
   input  wire logic [1:0] start_in,
   output logic      [1:0] manual_load_out
);
   int cnt [2] = '{0, 0};
   initial manual_load_out = 2'h0;
   // the host owns the discharge time: it sets the load bit and clears it when its timer runs out
   always @(posedge clock_in) begin
      for (int i = 0; i < 2; i++) begin
         if (start_in[i] && cnt[i] == 0) begin
            manual_load_out[i] <= 1'b1;
            cnt[i] <= HOLD;
         end else if (cnt[i] > 0) begin
            cnt[i] <= cnt[i] - 1;
            if (cnt[i] == 1) manual_load_out[i] <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
   import ppd_pkg::*;
;
   localparam int DC = 8;
   typedef struct {int s; int p; logic [3:0] e;} ppd_note_t;
   logic                     clk = 1'b0, nrst = 1'b0, hot = 1'b0, cool = 1'b1, uv = 1'b0, aden = 1'b0, rnd;
   logic [1:0]               hstart = 2'h0, mload;
   ppd_port_in_t [1:0]       drv, pbus;
   ppd_port_out_t [1:0]      pout;
   logic [7:0]               samp [2];
   logic [PPD_CHG_WIDTH-1:0] thr, tot [2];
   integer                   seed = 32'hBC684DC4;
   int                       mismatches = 0, total_checks = 0, cyc = 0;
   ppd_note_t                q [$];

   ppd_port_ctrl #(.DISCH_CYCLES(DC)) ppd_port_ctrl_inst (.clock_in(clk), .nrst_in(nrst),
      .die_temp_high_in(hot), .die_temp_cool_in(cool), .supply_undervoltage_in(uv),
      .auto_discharge_enable_in(aden), .port_in(pbus), .charge_sample_in(samp),
      .charge_threshold_in(thr), .port_out(pout), .charge_total_out(tot));
   ppd_host_model ppd_host_model_inst (.clock_in(clk), .start_in(hstart), .manual_load_out(mload));

   always_comb begin
      pbus = drv;
      pbus[0].manual_load = mload[0];
      pbus[1].manual_load = mload[1];
   end
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      #1;
      for (int p = 0; p < 2; p++) samp[p] = rnd ? {4'h0, 4'h1 | 4'($random(seed))} : 8'h00;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         conclude();
      end
   end

   function automatic logic [3:0] get(int s, int p);
      case (s)
         0: return {3'h0, pout[p].switch_closed};
         1: return {3'h0, pout[p].discharge_load};
         2: return {3'h0, pout[p].fault_alert};
         3: return {3'h0, pout[p].discharge_fault_flag};
         4: return {3'h0, pout[p].charge_limit_reached_flag};
         5: return pout[p].power_state;
         6: return {3'h0, pout[p].monitor_on};
         default: return {3'h0, tot[p] === '0};
      endcase
   endfunction
   // watcher: compares each noted expectation against the outputs of that moment
   initial forever begin
      wait (q.size() > 0);
      total_checks++;
      if (get(q[0].s, q[0].p) !== q[0].e) begin
         mismatches++;
         $display("MISMATCH t=%0t sel %0d port %0d exp %h got %h", $time, q[0].s, q[0].p, q[0].e,
                  get(q[0].s, q[0].p));
      end
      void'(q.pop_front());
   end
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic note(int s, int p, logic [3:0] e);
      q.push_back('{s, p, e});
      wait (q.size() == 0);
   endtask
   task automatic wait_for(int s, int p, logic [3:0] e, int lim);
      int k;
      k = 0;
      while (get(s, p) !== e && k < lim) begin
         step(1);
         k++;
      end
      note(s, p, e);
   endtask
   task automatic recover(int p);
      step(4);
      drv[p].err_clear = 1'b1;
      step(3);
      drv[p].err_clear = 1'b0;
      wait_for(5, p, PPD_ACTIVE, 60);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      drv = '0;
      drv[0].action_sel = PPD_BEH_RESET;
      drv[1].action_sel = PPD_BEH_RESET;
      thr = '0;
      rnd = 1'b1;
      samp[0] = 8'h00;
      samp[1] = 8'h00;
      step(3);
      note(5, 0, PPD_OFF);
      nrst = 1'b1;
      step(6);
      note(7, 0, 4'h1);
      drv[0].enable = 1'b1;
      drv[1].enable = 1'b1;
      for (int p = 0; p < 2; p++) wait_for(0, p, 4'h1, 20);
      $display("test reset and enable done");
      hot = 1'b1;
      cool = 1'b0;
      wait_for(5, 0, PPD_ERROR, 20);
      for (int p = 0; p < 2; p++) begin
         note(5, p, PPD_ERROR);
         note(2, p, 4'h1);
         note(0, p, 4'h0);
      end
      hot = 1'b0;
      step(12);
      for (int p = 0; p < 2; p++) note(5, p, PPD_ERROR);
      cool = 1'b1;
      for (int p = 0; p < 2; p++) recover(p);
      for (int p = 0; p < 2; p++) note(1, p, 4'h0);
      $display("test thermal done");
      drv[0].enable = 1'b0;
      wait_for(5, 0, PPD_OFF, 10);
      note(1, 0, 4'h0);
      hstart[0] = 1'b1;
      step(1);
      hstart[0] = 1'b0;
      wait_for(1, 0, 4'h1, 6);
      step(8);
      note(1, 0, 4'h1);
      wait_for(1, 0, 4'h0, 10);
      $display("test manual discharge done");
      aden = 1'b1;
      drv[0].enable = 1'b1;
      wait_for(5, 0, PPD_ACTIVE, 10);
      drv[0].vbus_above_test = 1'b1;
      drv[0].enable = 1'b0;
      wait_for(1, 0, 4'h1, 8);
      step(DC - 2);
      note(1, 0, 4'h1);
      wait_for(3, 0, 4'h1, 8);
      wait_for(5, 0, PPD_ERROR, 3);
      drv[0].vbus_above_test = 1'b0;
      drv[0].enable = 1'b1;
      step(4);
      drv[0].err_clear = 1'b1;
      wait_for(1, 0, 4'h1, 10);
      drv[0].err_clear = 1'b0;
      wait_for(1, 0, 4'h0, DC + 4);
      for (int k = 0; k < 3; k++) begin
         wait_for(5, 1, PPD_ACTIVE, 40);
         if (k == 0) drv[1].disch_cmd = 1'b1;
         else if (k == 1) drv[1].sleep_cmd = 1'b1;
         else uv = 1'b1;
         wait_for(1, 1, 4'h1, 10);
         drv[1].disch_cmd = 1'b0;
         if (k == 1) note(5, 1, PPD_SLEEP);
         wait_for(1, 1, 4'h0, DC + 4);
         note(3, 1, 4'h0);
         drv[1].sleep_cmd = 1'b0;
         uv = 1'b0;
      end
      $display("test auto discharge done");
      aden = 1'b0;
      recover(0);
      thr = 24'h0000C0;
      for (int c = 0; c < 4; c++) begin
         rnd = 1'b0;
         drv[0].action_sel = 2'(3 - c);
         drv[0].charge_limit_reached_flag_rst = 1'b1;
         step(1);
         drv[0].charge_limit_reached_flag_rst = 1'b0;
         step(2);
         rnd = 1'b1;
         step(2);
         drv[0].action_sel = 2'(c);
         note(2, 0, 4'h0);
         note(0, 0, 4'h1);
         note(7, 0, 4'h0);
         wait_for(4, 0, 4'h1, 200);
         rnd = 1'b0;
         step(3);
         note(2, 0, {3'h0, c < 2});
         note(0, 0, {3'h0, c == 0 || c == 3});
         if (c == 0) begin
            drv[0].action_sel = PPD_BEH_IGNORE;
            wait_for(2, 0, 4'h0, 5);
         end else if (c == 1) begin
            drv[0].enable = 1'b0;
            wait_for(5, 0, PPD_OFF, 10);
            drv[0].enable = 1'b1;
            wait_for(5, 0, PPD_ACTIVE, 10);
            note(0, 0, 4'h0);
         end else if (c == 2) begin
            note(5, 0, PPD_SLEEP);
            note(6, 0, 4'h0);
            drv[0].enable = 1'b0;
            step(6);
            note(5, 0, PPD_SLEEP);
            drv[0].enable = 1'b1;
         end
         drv[0].charge_limit_reached_flag_rst = 1'b1;
         step(1);
         drv[0].charge_limit_reached_flag_rst = 1'b0;
         wait_for(4, 0, 4'h0, 5);
         note(7, 0, 4'h1);
         note(2, 0, 4'h0);
         if (c == 1 || c == 2) wait_for(0, 0, 4'h1, 10);
      end
      $display("test rationing done");
      conclude();
   end
endmodule
`default_nettype wire
